//--- logic/gpio_irq_pending_mask_regs.sv
// Second-level pending and mask registers for fifteen pins, with summary request.
// Assumes register requests come decoded from the serial port, one cycle each.
// Assumes pin_in is raw and asynchronous, while edge_select is a steady level on clk.
// Assumes the first-level controller and the pin edge configuration sit outside.
// Assumes rst_n may be released in step with clk.
// How it works
// - The upper pending register at 0x0b holds pins 14..8 in bits 6..0, bit 7 reads zero, reset zero.
// - The lower pending register at 0x0c holds pins 7..0, reset zero.
// - A pending flag reads one while its pin interrupt is outstanding and zero otherwise.
// - The upper mask register at 0x19 holds pin masks 14..8, bit 7 zero, reset 0x7f.
// - The lower mask register at 0x1a holds pin masks 7..0, reset 0xff.
// - A mask bit of one suppresses its pin, zero lets it through, and masks are read/write.
// - Writing one to a pending flag clears it.
// - An event sets its flag only while its mask is zero.
// - A flag is set on the pin edge chosen by its edge select field.
// - The summary request stands while any unmasked pending flag is set.
`timescale 1ns/10ps
`default_nettype none
`include "pin_irq_defs.svh"
module gpio_irq_pending_mask_regs
	import pin_irq_pkg::*;
#(
	parameter int PINS = 15
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire reg_req_t reg_req,
	output logic [7:0] rdata,
	output logic rvalid,
	input wire logic [PINS-1:0] pin_in,
	input wire edge_select_t [PINS-1:0] edge_select,
	output logic first_level_summary
);

	// Synchroniser stages for the raw pins
	logic [PINS-1:0] sync1_ff;
	logic [PINS-1:0] sync2_ff;

	// Register state and registered outputs
	logic [7:0] mask_high_ff;
	logic [7:0] mask_low_ff;
	logic [7:0] rdata_ff;
	logic rvalid_ff;
	logic summary_ff;

	// Per-pin vectors, bit i belongs to pin i
	logic [PINS-1:0] pending;
	logic [PINS-1:0] clear;
	logic [PINS-1:0] mask_all;
	logic [PINS-1:0] live;

	// Register port decode
	logic hit_ph;
	logic hit_pl;
	logic hit_mh;
	logic hit_ml;
	logic wr_ph;
	logic wr_pl;
	logic wr_mh;
	logic wr_ml;
	logic [7:0] wdata_high;
	logic [7:0] clr_high;
	logic [7:0] clr_low;
	logic [7:0] nxt_mask_high;
	logic [7:0] nxt_mask_low;

	// Read-back views and next values of the outputs
	logic [15:0] pend16;
	logic [7:0] rd_pending_high;
	logic [7:0] rd_pending_low;
	logic [7:0] rd_mask_high;
	logic [7:0] rd_mask_low;
	logic [7:0] rd_mux;
	logic [7:0] nxt_rdata;
	logic nxt_rvalid;
	logic nxt_summary;

	// Pins come from outside the clock domain, so two stages before any logic
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sync1_ff <= '0;
		end else begin
			sync1_ff <= pin_in;
		end
	end

	// Nothing but this stage reads the first one
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sync2_ff <= '0;
		end else begin
			sync2_ff <= sync1_ff;
		end
	end

	// Register port decode, one request per cycle
	// Writes to unmapped offsets match no hit and change nothing
	assign hit_ph = reg_req.addr == `PENDING_HIGH_ADDR;
	assign hit_pl = reg_req.addr == `PENDING_LOW_ADDR;
	assign hit_mh = reg_req.addr == `MASK_HIGH_ADDR;
	assign hit_ml = reg_req.addr == `MASK_LOW_ADDR;
	assign wr_ph = reg_req.wr & hit_ph;
	assign wr_pl = reg_req.wr & hit_pl;
	assign wr_mh = reg_req.wr & hit_mh;
	assign wr_ml = reg_req.wr & hit_ml;
	// Reserved bit 7 of the upper registers is dropped before it reaches any state
	assign wdata_high = reg_req.wdata & `HIGH_USED_BITS;
	// Write-one clear; a zero bit leaves its flag alone
	assign clr_high = wr_ph ? wdata_high : 8'h00;
	assign clr_low = wr_pl ? reg_req.wdata : 8'h00;
	assign nxt_mask_high = wr_mh ? wdata_high : mask_high_ff;
	assign nxt_mask_low = wr_ml ? reg_req.wdata : mask_low_ff;

	// Routing per pin keeps the register layout fixed even if PINS is trimmed
	genvar i;
	generate
		for (i = 0; i < PINS; i++) begin : g_map
			if (i < 8) begin : g_low
				assign clear[i] = clr_low[i];
				assign mask_all[i] = mask_low_ff[i];
			end else begin : g_high
				assign clear[i] = clr_high[i-8];
				assign mask_all[i] = mask_high_ff[i-8];
			end
		end
	endgenerate

	// One flag per pin, each with its own edge detector
	generate
		for (i = 0; i < PINS; i++) begin : g_flag
			pin_irq_flag u_flag (
				.clk(clk),
				.rst_n(rst_n),
				.pin_sync(sync2_ff[i]),
				.edge_select(edge_select[i]),
				.mask(mask_all[i]),
				.clear(clear[i]),
				.pending(pending[i])
			);
		end
	endgenerate

	// Read-back views; reserved bits are forced to zero here
	assign pend16 = 16'(pending);
	assign rd_pending_high = {1'b0, pend16[14:8]};
	assign rd_pending_low = pend16[7:0];
	assign rd_mask_high = {1'b0, mask_high_ff[6:0]};
	assign rd_mask_low = mask_low_ff;
	always_comb begin
		if (hit_ph) begin
			rd_mux = rd_pending_high;
		end else if (hit_pl) begin
			rd_mux = rd_pending_low;
		end else if (hit_mh) begin
			rd_mux = rd_mask_high;
		end else if (hit_ml) begin
			rd_mux = rd_mask_low;
		end else begin
			// Unmapped offsets read as zero
			rd_mux = 8'h00;
		end
	end
	// Read data holds between reads, so a slow host can still pick it up
	assign nxt_rdata = reg_req.rd ? rd_mux : rdata_ff;
	assign nxt_rvalid = reg_req.rd;
	assign live = pending & ~mask_all;
	// Flags only set while unmasked, but a later mask still hides a stale flag
	assign nxt_summary = |live;

	// Masks start set so no pin can interrupt before the host has set it up
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			mask_high_ff <= `MASK_HIGH_RST;
		end else begin
			mask_high_ff <= nxt_mask_high;
		end
	end

	// Lower mask, same reasoning as the upper one
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			mask_low_ff <= `MASK_LOW_RST;
		end else begin
			mask_low_ff <= nxt_mask_low;
		end
	end

	// Read data register, changed only by a read
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rdata_ff <= 8'h00;
		end else begin
			rdata_ff <= nxt_rdata;
		end
	end

	// One-cycle answer strobe, exactly one cycle after the read request
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rvalid_ff <= 1'b0;
		end else begin
			rvalid_ff <= nxt_rvalid;
		end
	end

	// Registered so the request line cannot glitch while flags settle
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			summary_ff <= 1'b0;
		end else begin
			summary_ff <= nxt_summary;
		end
	end

	// Every output comes straight from a flop
	assign rdata = rdata_ff;
	assign rvalid = rvalid_ff;
	assign first_level_summary = summary_ff;
endmodule // gpio_irq_pending_mask_regs
`default_nettype wire

//--- logic/pin_irq_flag.sv
// One pending flag: edge detect on a synchronised pin, mask gate, write-one clear.
// Assumes pin_sync is already synchronised to clk.
`timescale 1ns/10ps
`default_nettype none
module pin_irq_flag
	import pin_irq_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic pin_sync,
	input wire edge_select_t edge_select,
	input wire logic mask,
	input wire logic clear,
	output logic pending
);
	logic prev_ff;
	logic pending_ff;
	wire rise = pin_sync & ~prev_ff;
	wire fall = ~pin_sync & prev_ff;
	wire hit = ((edge_select == edge_rise) & rise) | ((edge_select == edge_fall) & fall) |
		((edge_select == edge_both) & (rise | fall));
	wire set_ev = hit & ~mask;
	// Set wins over a clear in the same cycle so no event is lost
	wire nxt_pending = set_ev | (pending_ff & ~clear);
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			prev_ff <= 1'b0;
			pending_ff <= 1'b0;
		end else begin
			prev_ff <= pin_sync;
			pending_ff <= nxt_pending;
		end
	end
	assign pending = pending_ff;
endmodule // pin_irq_flag
`default_nettype wire

//--- shared/pin_irq_defs.svh
// Register offsets, reset values and field layout of the pin interrupt block.
// Assumes an 8-bit register address and 8-bit data from the serial register port.
`ifndef PIN_IRQ_DEFS_SVH
`define PIN_IRQ_DEFS_SVH
`define PENDING_HIGH_ADDR 8'h0b
`define PENDING_LOW_ADDR 8'h0c
`define MASK_HIGH_ADDR 8'h19
`define MASK_LOW_ADDR 8'h1a
`define PENDING_HIGH_RST 8'h00
`define PENDING_LOW_RST 8'h00
`define MASK_HIGH_RST 8'h7f
`define MASK_LOW_RST 8'hff
`define HIGH_USED_BITS 8'h7f
`define EDGE_RISE 2'h1
`define EDGE_FALL 2'h2
`define EDGE_BOTH 2'h3
`endif

//--- shared/pin_irq_pkg.sv
// Types shared by the pin interrupt block.
// Assumes a register access port that is already decoded from the serial link.
package pin_irq_pkg;
	typedef enum logic [1:0] {edge_off, edge_rise, edge_fall, edge_both} edge_select_t;
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} reg_req_t;
endpackage

//--- verification/host_model.sv
// Host side of the register port; notes each expected read answer.
// Assumes the bench pops exp_q on every rvalid.
`timescale 1ns/10ps
`default_nettype none
module host_model import pin_irq_pkg::*; (
	input wire logic clk,
	output var reg_req_t req
);
	logic [7:0] exp_q[$];
	initial req = '0;
	// Held until the next call, so calls in a row give back-to-back strobes
	task acc(input logic w, r, input logic [7:0] a, d, e);
		@(posedge clk) #1 req = '{w, r, a, d};
		if (r) exp_q.push_back(e);
	endtask
endmodule // host_model
`default_nettype wire

//--- verification/pin_irq_monitor.sv
// Port checks for the pin interrupt block.
// Assumes a bind onto the block's top module.
`timescale 1ns/10ps
`default_nettype none
module pin_irq_monitor import pin_irq_pkg::*; (
	input wire logic clk,
	input wire logic rst_n,
	input wire reg_req_t reg_req,
	input wire logic [7:0] rdata,
	input wire logic rvalid,
	input wire logic first_level_summary
);
	logic mwr_ff;
	wire logic w = reg_req.wr;
	wire logic r = reg_req.rd;
	wire logic [7:0] a = reg_req.addr;
	// Masks keep reset values until the first mask write
	always_ff @(posedge clk or negedge rst_n)
		if (!rst_n) mwr_ff <= 1'b0;
		else if (w && (a == 8'h19 || a == 8'h1a)) mwr_ff <= 1'b1;
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	sequence mask_all_s;
		w && a == 8'h1a && reg_req.wdata == 8'hff ##1 w && a == 8'h19 && reg_req.wdata == 8'hff;
	endsequence
	rd_answer_a: assert property (r |=> rvalid) else $error("no answer");
	rd_cause_a: assert property (rvalid |-> $past(r)) else $error("stray answer");
	unmapped_rd_a: assert property (r && a == 8'h02 |=> rdata == 8'h00) else $error("hole");
	pend_top_a: assert property (r && a == 8'h0b |=> !rdata[7]) else $error("bit 7");
	mask_lo_a: assert property (r && a == 8'h1a && !mwr_ff |=> rdata == 8'hff) else $error("mlo");
	mask_hi_a: assert property (r && a == 8'h19 && !mwr_ff |=> rdata == 8'h7f) else $error("mhi");
	masked_sum_a: assert property (mask_all_s |-> ##2 !first_level_summary) else $error("sum");
	fresh_sum_a: assert property (!mwr_ff |-> !first_level_summary) else $error("early");
endmodule // pin_irq_monitor
`default_nettype wire

//--- verification/testbench.sv
// Bench top: clock, reset, scenarios, verdict.
// Assumes the block and host_model are compiled first.
`timescale 1ns/10ps
`default_nettype none
module testbench;
	import pin_irq_pkg::*;
	logic clk = 0, rst_n = 0, rvalid, sum;
	logic [14:0] pin_in = '0, v;
	edge_select_t [14:0] es;
	reg_req_t req;
	logic [7:0] rdata;
	int fails = 0, total_checks = 0, cyc = 0;
	always #12.5 clk = ~clk;
	host_model host (.clk(clk), .req(req));
	gpio_irq_pending_mask_regs dut (.clk(clk), .rst_n(rst_n), .reg_req(req), .rdata(rdata),
		.rvalid(rvalid), .pin_in(pin_in), .edge_select(es), .first_level_summary(sum));
	task chk(input logic [7:0] g, x);
		total_checks++;
		if (g !== x) begin fails++; $display("[ERR] %0t %h %h", $time, g, x); end
	endtask
	task end_of_test;
		if (fails == 0 && total_checks > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	task rd(input logic [7:0] a, e); host.acc(0, 1, a, 0, e); endtask
	task wr(input logic [7:0] a, d); host.acc(1, 0, a, d, 0); endtask
	task pend(input logic [14:0] x); rd(8'h0b, {1'b0, x[14:8]}); rd(8'h0c, x[7:0]); endtask
	// Six idle cycles cover two sync stages, the flag and the summary
	task pins(input logic [14:0] p); pin_in = p; repeat (6) host.acc(0, 0, 0, 0, 0); endtask
	function automatic logic [14:0] hit(input logic up);
		for (int i = 0; i < 15; i++)
			hit[i] = v[i] && (es[i] == edge_both || es[i] == (up ? edge_rise : edge_fall));
	endfunction
	// Outputs are looked at on the falling edge, where they are settled
	always @(negedge clk) begin
		cyc++;
		if (rvalid === 1'b1) chk(rdata, host.exp_q.pop_front());
		if (cyc > 2000) begin fails++; end_of_test; end
	end
	initial begin
		foreach (es[i]) es[i] = edge_off;
		void'($urandom(7));
		v = 15'($urandom);
		foreach (es[i]) es[i] = edge_select_t'($urandom % 4);
		repeat (20) @(posedge clk);
		#1 rst_n = 1;
		pend(15'h0000);
		rd(8'h19, 8'h7f);
		rd(8'h1a, 8'hff);
		rd(8'h02, 8'h00);
		pins(v);
		pend(15'h0000);
		pins(15'h0000);
		wr(8'h1a, 8'h00);
		wr(8'h19, 8'h80);
		rd(8'h19, 8'h00);
		pins(v);
		pend(hit(1));
		chk(sum, |hit(1));
		wr(8'h0b, 8'h00);
		wr(8'h0c, 8'h00);
		pend(hit(1));
		wr(8'h0b, 8'hff);
		wr(8'h0c, 8'hff);
		host.acc(0, 0, 0, 0, 0);
		host.acc(0, 0, 0, 0, 0);
		chk(sum, 8'h00);
		pins(15'h0000);
		pend(hit(0));
		chk(sum, |hit(0));
		wr(8'h1a, 8'hff);
		wr(8'h19, 8'hff);
		pins(15'h0000);
		chk(sum, 8'h00);
		pend(hit(0));
		pins(15'h0000);
		end_of_test;
	end
endmodule // testbench
bind gpio_irq_pending_mask_regs pin_irq_monitor mon (.clk(clk), .rst_n(rst_n),
	.reg_req(reg_req), .rdata(rdata), .rvalid(rvalid), .first_level_summary(first_level_summary));
`default_nettype wire
